/* include/amc_defines.svh */
// Constants of the operating mode control block
`ifndef AMC_DEFINES_SVH
`define AMC_DEFINES_SVH
`define AMC_MODE_RESET 16'h01b0
`define AMC_MD_HI 15
`define AMC_MD_LO 13
`define AMC_POL_BIT 12
`define AMC_DEN_BIT 11
`define AMC_D1_BIT 10
`define AMC_D0_BIT 9
`define AMC_WL_BIT 8
`define AMC_REF_BIT 7
`define AMC_RN_HI 5
`define AMC_RN_LO 4
`define AMC_CLK_OUTPUT_GATE_BIT 3
`define AMC_BO_BIT 2
`define AMC_CH_HI 1
`define AMC_CH_LO 0
`define AMC_SETTLE_TICKS 8'h03
`define AMC_CAL_TICKS 8'h02
`define AMC_RES_W 24
`endif

/* include/amc_pkg.sv */
// Types of the operating mode control block
package amc_pkg;
  typedef enum logic [2:0] {
    AMC_MD_IDLE = 3'h0,
    AMC_MD_CONT = 3'h1,
    AMC_MD_SINGLE = 3'h2,
    AMC_MD_STBY = 3'h3,
    AMC_MD_IZS = 3'h4,
    AMC_MD_IFS = 3'h5,
    AMC_MD_SZS = 3'h6,
    AMC_MD_SFS = 3'h7
  } amc_mode_t;
  typedef enum logic [1:0] {
    AMC_ST_IDLE = 2'b00,
    AMC_ST_RUN = 2'b01,
    AMC_ST_CAL = 2'b11,
    AMC_ST_STBY = 2'b10
  } amc_state_t;
  typedef struct packed {
    logic pos_src_en;
    logic neg_sink_en;
  } amc_burn_t;
  typedef struct packed {
    logic offset_wr;
    logic gain_wr;
    logic [1:0] pair;
  } amc_cal_wr_t;
endpackage

/* rtl/amc_sync2.sv */
// Two flip-flop synchroniser
`timescale 1ns/100ps
`default_nettype none
module amc_sync2 (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Data
  input wire logic async_i,
  output logic sync_o
);
  logic meta_q;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* rtl/amc_mode_ctrl.sv */
// Operating mode sequencer and mode register
`timescale 1ns/100ps
`default_nettype none
`include "amc_defines.svh"
module amc_mode_ctrl (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Mode register write and read
  input wire logic mode_wr_i,
  input wire logic [15:0] mode_wdata_i,
  output logic [15:0] mode_rdata_o,
  // Data register read
  input wire logic data_rd_i,
  input wire logic [4:0] data_rd_bits_i,
  // Pins
  input wire logic sync_n_i,
  input wire logic standby_n_i,
  input wire logic ext_clk_i,
  // Filter side
  input wire logic update_tick_i,
  input wire logic [`AMC_RES_W-1:0] raw_result_i,
  input wire logic cal_done_tick_i,
  output logic mod_reset_o,
  output logic standby_o,
  output logic [`AMC_RES_W-1:0] data_reg_o,
  output logic [4:0] read_len_o,
  output logic ready_o,
  output amc_pkg::amc_cal_wr_t cal_wr_o,
  output logic cal_active_o,
  // Analog steering
  output logic [1:0] span_o,
  output logic hi_ref_o,
  output amc_pkg::amc_burn_t burn_o,
  output logic [1:0] pair_sel_o,
  output logic short_test_o,
  output logic straight_bin_o,
  // Digital pin outputs
  output logic [1:0] pin_out_o,
  output logic [1:0] pin_oe_o,
  output logic mclk_out_o
);
  import amc_pkg::*;

  logic [15:0] mode_q;
  logic [15:0] mode_d;
  amc_state_t state_q;
  amc_state_t state_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [`AMC_RES_W-1:0] data_q;
  logic ready_q;
  logic ready_d;
  logic sync_n_s;
  logic stby_n_s;
  logic clk_s;
  logic clk_s_q;

  amc_sync2 u_sync_sync (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .async_i(sync_n_i),
    .sync_o(sync_n_s)
  );
  amc_sync2 u_sync_stby (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .async_i(standby_n_i),
    .sync_o(stby_n_s)
  );
  amc_sync2 u_sync_clk (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .async_i(ext_clk_i),
    .sync_o(clk_s)
  );

  // Field decode
  wire amc_mode_t md_w = amc_mode_t'(mode_q[`AMC_MD_HI:`AMC_MD_LO]);
  wire is_cal_w = mode_q[`AMC_MD_HI];
  wire pin_stby_w = !stby_n_s;
  wire pin_sync_w = !sync_n_s;
  wire wl_w = mode_q[`AMC_WL_BIT];
  wire den_w = mode_q[`AMC_DEN_BIT];
  wire [1:0] ch_w = mode_q[`AMC_CH_HI:`AMC_CH_LO];
  wire settled_w = (cnt_q == `AMC_SETTLE_TICKS);
  wire cal_end_w = (cnt_q == `AMC_CAL_TICKS) && cal_done_tick_i;
  wire load_w = (state_q == AMC_ST_RUN) && update_tick_i &&
                ((md_w == AMC_MD_CONT) || settled_w);
  wire single_end_w = load_w && (md_w == AMC_MD_SINGLE);
  wire [4:0] len_w = wl_w ? 5'h18 : 5'h10;

  // Mode register: writes win, self clear after cal or single
  always_comb begin
    mode_d = mode_q;
    if (mode_wr_i) begin
      mode_d = mode_wdata_i;
    end else if (single_end_w) begin
      mode_d[`AMC_MD_HI:`AMC_MD_LO] = 3'h0;
    end else if ((state_q == AMC_ST_CAL) && cal_end_w) begin
      mode_d[`AMC_MD_HI:`AMC_MD_LO] = 3'h0;
    end
  end

  // Sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (mode_wr_i) begin
      cnt_d = 8'h00;
      state_d = AMC_ST_IDLE;
    end else if (pin_stby_w || (md_w == AMC_MD_STBY)) begin
      state_d = AMC_ST_STBY;
    end else if (pin_sync_w || (md_w == AMC_MD_IDLE)) begin
      state_d = AMC_ST_IDLE;
      cnt_d = 8'h00;
    end else begin
      case (state_q)
        AMC_ST_IDLE, AMC_ST_STBY: begin
          cnt_d = 8'h00;
          state_d = is_cal_w ? AMC_ST_CAL : AMC_ST_RUN;
        end
        AMC_ST_RUN: begin
          if (update_tick_i && !settled_w) begin
            cnt_d = cnt_q + 8'h01;
          end
          if (single_end_w) begin
            state_d = AMC_ST_IDLE;
          end
        end
        AMC_ST_CAL: begin
          if (cal_done_tick_i && (cnt_q != `AMC_CAL_TICKS)) begin
            cnt_d = cnt_q + 8'h01;
          end
          if (cal_end_w) begin
            state_d = AMC_ST_IDLE;
          end
        end
        default: state_d = AMC_ST_IDLE;
      endcase
    end
  end

  // Ready: low on load, high during cal and after full read
  always_comb begin
    ready_d = ready_q;
    if ((state_q == AMC_ST_CAL) && !cal_end_w) begin
      ready_d = 1'b1;
    end else if ((state_q == AMC_ST_CAL) && cal_end_w) begin
      ready_d = 1'b0;
    end else if (load_w) begin
      ready_d = 1'b0;
    end else if (data_rd_i && (data_rd_bits_i == len_w)) begin
      ready_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_q <= `AMC_MODE_RESET;
      state_q <= AMC_ST_IDLE;
      cnt_q <= 8'h00;
      ready_q <= 1'b1;
      clk_s_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      ready_q <= ready_d;
      clk_s_q <= clk_s;
    end
  end

  // Result coding
  wire [`AMC_RES_W-1:0] coded_w = mode_q[`AMC_POL_BIT] ? raw_result_i :
    {~raw_result_i[`AMC_RES_W-1], raw_result_i[`AMC_RES_W-2:0]};

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_q <= 24'h000000;
    end else if (load_w) begin
      data_q <= coded_w;
    end
  end

  // Calibration register write strobes
  wire cal_fire_w = (state_q == AMC_ST_CAL) && cal_end_w;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cal_wr_o <= '0;
    end else begin
      cal_wr_o.offset_wr <= cal_fire_w && ((md_w == AMC_MD_IZS) ||
        (md_w == AMC_MD_IFS) || (md_w == AMC_MD_SZS));
      cal_wr_o.gain_wr <= cal_fire_w &&
        ((md_w == AMC_MD_IFS) || (md_w == AMC_MD_SFS));
      cal_wr_o.pair <= (ch_w == 2'h3) ? 2'h2 : {1'b0, ch_w[0]};
    end
  end

  // Outputs
  assign mode_rdata_o = mode_q;
  assign mod_reset_o = (state_q == AMC_ST_IDLE) ||
                       (state_q == AMC_ST_STBY);
  assign standby_o = (state_q == AMC_ST_STBY);
  assign data_reg_o = data_q;
  assign read_len_o = len_w;
  assign ready_o = ready_q;
  assign cal_active_o = (state_q == AMC_ST_CAL);
  assign span_o = mode_q[`AMC_RN_HI:`AMC_RN_LO];
  assign hi_ref_o = mode_q[`AMC_REF_BIT];
  assign straight_bin_o = mode_q[`AMC_POL_BIT];
  assign burn_o.pos_src_en = mode_q[`AMC_BO_BIT];
  assign burn_o.neg_sink_en = mode_q[`AMC_BO_BIT];
  assign pair_sel_o = ch_w;
  assign short_test_o = (ch_w == 2'h2);
  assign pin_oe_o = {den_w, den_w};
  assign pin_out_o = den_w ? {mode_q[`AMC_D1_BIT], mode_q[`AMC_D0_BIT]} :
                     2'h0;
  assign mclk_out_o = mode_q[`AMC_CLK_OUTPUT_GATE_BIT] ? 1'b0 : clk_s_q;

  // Checks
  reset_mode_a: assert property (@(posedge core_clk_i)
    $rose(resetn_i) |-> mode_q == `AMC_MODE_RESET)
    else $error("mode reset value wrong");
  stby_state_a: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    (!mode_wr_i && pin_stby_w) |=> standby_o)
    else $error("standby not entered");
  sync_keep_a: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    (!mode_wr_i && pin_sync_w && !single_end_w && !cal_fire_w) |=>
    $stable(mode_q))
    else $error("sync pin changed mode field");
  cal_ready_a: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    (cal_active_o && !cal_end_w) |=> ready_q)
    else $error("ready low during calibration");
  cal_clear_a: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    (cal_fire_w && !mode_wr_i) |=> (mode_q[15:13] == 3'h0) && !ready_q)
    else $error("calibration did not return idle");
  single_end_a: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    (single_end_w && !mode_wr_i) |=> mode_q[15:13] == 3'h0 &&
    data_q == $past(coded_w))
    else $error("single conversion end wrong");
  gain_only_a: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    (cal_fire_w && md_w == AMC_MD_SFS) |=> cal_wr_o.gain_wr &&
    !cal_wr_o.offset_wr)
    else $error("system full cal strobes wrong");
  clk_gate_a: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    mode_q[`AMC_CLK_OUTPUT_GATE_BIT] |-> !mclk_out_o)
    else $error("clock output not low");
  pin_drive_a: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    !den_w |-> (pin_oe_o == 2'h0) && (pin_out_o == 2'h0))
    else $error("pins driven while disabled");
endmodule
`default_nettype wire

/* bench/amc_host_model.sv */
// Host side model that writes the mode register and ends data reads
`timescale 1ns/100ps
`default_nettype none
module amc_host_model #(
  parameter logic REF_5V = 1'b1
) (
  // Clock
  input wire logic core_clk_i,
  // Register port
  output logic mode_wr_o,
  output logic [15:0] mode_wdata_o,
  output logic data_rd_o,
  output logic [4:0] data_rd_bits_o
);
  initial begin
    mode_wr_o = 1'b0;
    mode_wdata_o = 16'h0000;
    data_rd_o = 1'b0;
    data_rd_bits_o = 5'h00;
  end
  // Released data lines show inverted values; strobes return low
  task automatic wr(input logic [15:0] v);
    @(negedge core_clk_i);
    mode_wr_o = 1'b1;
    mode_wdata_o = {v[15:8], REF_5V, 1'b0, v[5:0]};
    @(negedge core_clk_i);
    mode_wr_o = 1'b0;
    mode_wdata_o = ~mode_wdata_o;
  endtask
  task automatic rd(input logic [4:0] n);
    @(negedge core_clk_i);
    data_rd_o = 1'b1;
    data_rd_bits_o = n;
    @(negedge core_clk_i);
    data_rd_o = 1'b0;
    data_rd_bits_o = ~n;
  endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench of the operating mode control block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import amc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, xclk = 1'b0;
  logic sync_n = 1'b1, stby_n = 1'b1, tick = 1'b0, ctick = 1'b0;
  logic [23:0] raw = 24'h000000;
  logic mwr, drd, mres, stby, rdy, cact, href, shrt, sbin, mclk;
  logic [15:0] wd, rdata;
  logic [4:0] rbits, rlen;
  logic [23:0] data;
  amc_cal_wr_t calw, cal_seen;
  amc_burn_t burn;
  logic [1:0] span, pair, pout, poe;
  int fail_count = 0, checks = 0;
  always #5 clk = ~clk;
  always #40 xclk = ~xclk;
  always @(posedge clk) if (calw.offset_wr | calw.gain_wr) cal_seen <= calw;
  amc_host_model host_u (.core_clk_i(clk), .mode_wr_o(mwr),
    .mode_wdata_o(wd), .data_rd_o(drd), .data_rd_bits_o(rbits));
  amc_mode_ctrl dut_u (.core_clk_i(clk), .resetn_i(rst_n), .mode_wr_i(mwr),
    .mode_wdata_i(wd), .mode_rdata_o(rdata), .data_rd_i(drd),
    .data_rd_bits_i(rbits), .sync_n_i(sync_n), .standby_n_i(stby_n),
    .ext_clk_i(xclk), .update_tick_i(tick), .raw_result_i(raw),
    .cal_done_tick_i(ctick), .mod_reset_o(mres), .standby_o(stby),
    .data_reg_o(data), .read_len_o(rlen), .ready_o(rdy), .cal_wr_o(calw),
    .cal_active_o(cact), .span_o(span), .hi_ref_o(href), .burn_o(burn),
    .pair_sel_o(pair), .short_test_o(shrt), .straight_bin_o(sbin),
    .pin_out_o(pout), .pin_oe_o(poe), .mclk_out_o(mclk));
  task automatic chk(input string n, input logic [23:0] e, g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  function automatic logic [1:0] cpair(input logic [1:0] c);
    return (c == 2'b01) ? 2'd1 : (c == 2'b11) ? 2'd2 : 2'd0;
  endfunction
  // Raw input is offset binary; bipolar coding flips the msb
  function automatic logic [23:0] coded(input logic [23:0] v, input logic p);
    return p ? v : {~v[23], v[22:0]};
  endfunction
  task automatic chk_cfg(input logic [15:0] w);
    chk("rlen", w[8] ? 24'd24 : 24'd16, rlen);
    chk("span", w[5:4], span);
    chk("href", 1'b1, href);
    chk("sbin", w[12], sbin);
    chk("poe", {2{w[11]}}, poe);
    if (w[11]) chk("pout", w[10:9], pout);
    chk("burn", {2{w[2]}}, burn);
    chk("pair", w[1:0], pair);
    chk("short", w[1:0] == 2'b10, shrt);
  endtask
  initial begin
    logic [15:0] w;
    logic [23:0] r;
    int i;
    int k;
    void'($urandom(78503));
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    cyc(3);
    chk("mreset", 16'h01b0, rdata);
    chk("mres", 1'b1, mres);
    chk_cfg(16'h01b0);
    for (i = 0; i < 12; i++) begin
      w = (i == 0) ? 16'h1fbf : {3'h0, 13'($urandom)};
      w[7:6] = 2'b10;
      host_u.wr(w);
      cyc(4);
      chk("mode", w, rdata);
      chk_cfg(w);
      r = 24'h0;
      for (k = 0; k < 16; k++) begin
        cyc(1);
        r[0] = r[0] | mclk;
      end
      chk("mclk", !w[3], r[0]);
    end
    for (i = 0; i < 2; i++) begin
      w = {3'h1, 4'h0, 1'(i), 8'hb0};
      host_u.wr(w);
      cyc(3);
      r = 24'($urandom);
      raw = r;
      pulse(tick);
      cyc(1);
      chk("data", coded(r, w[12]), data);
      chk("rdy_lo", 1'b0, rdy);
      host_u.rd(w[8] ? 5'd24 : 5'd16);
      cyc(1);
      chk("rdy_rd", 1'b1, rdy);
    end
    sync_n = 1'b0;
    cyc(4);
    raw = ~r;
    pulse(tick);
    cyc(1);
    chk("sync_rst", 1'b1, mres);
    chk("sync_hold", coded(r, 1'b0), data);
    chk("sync_md", 3'h1, rdata[15:13]);
    sync_n = 1'b1;
    stby_n = 1'b0;
    cyc(4);
    chk("stby_pin", 1'b1, stby);
    chk("stby_md", 3'h1, rdata[15:13]);
    stby_n = 1'b1;
    host_u.wr(16'h61b0);
    cyc(3);
    chk("stby_cd", 1'b1, stby);
    host_u.wr(16'h41b0);
    cyc(3);
    repeat (2) pulse(tick);
    host_u.wr(16'h41b0);
    cyc(3);
    repeat (2) pulse(tick);
    chk("restart", 3'h2, rdata[15:13]);
    pulse(tick);
    r = 24'($urandom);
    raw = r;
    pulse(tick);
    cyc(2);
    chk("sgl_data", coded(r, 1'b0), data);
    chk("sgl_idle", 3'h0, rdata[15:13]);
    chk("sgl_rst", 1'b1, mres);
    for (i = 4; i < 8; i++) begin
      w = {3'(i), 11'h06c, 2'($urandom)};
      cal_seen = '0;
      host_u.wr(w);
      cyc(3);
      chk("cal_rdy", 1'b1, rdy);
      chk("cal_act", 1'b1, cact);
      repeat (3) pulse(ctick);
      cyc(3);
      chk("cal_wr", {i != 7, i[0], cpair(w[1:0])}, cal_seen);
      chk("cal_end", 1'b0, rdy);
      chk("cal_idle", 3'h0, rdata[15:13]);
    end
    finish_test();
  end
endmodule
`default_nettype wire
